// ### rtl/rmpu_defs.vh
`ifndef RMPU_DEFS_VH
`define RMPU_DEFS_VH

// ==========================================================
// Register offsets, low twelve byte-address bits
`define RMPU_OFF_TYPE 12'hD90
`define RMPU_OFF_CTRL 12'hD94
`define RMPU_OFF_SEL 12'hD98
`define RMPU_OFF_BASE 12'hD9C
`define RMPU_OFF_LIMIT 12'hDA0
`define RMPU_OFF_ALIAS_FIRST 12'hDA4
`define RMPU_OFF_ALIAS_LAST 12'hDB8
`define RMPU_OFF_ATTR_LOW 12'hDC0
`define RMPU_OFF_ATTR_HIGH 12'hDC4

// ==========================================================
// Field positions
`define RMPU_TYPE_COUNT_MSB 15
`define RMPU_TYPE_COUNT_LSB 8
`define RMPU_TYPE_SEPARATE 0
`define RMPU_CTRL_ENABLE 0
`define RMPU_CTRL_HANDLER 1
`define RMPU_CTRL_BACKGROUND 2
`define RMPU_ADDR_MSB 31
`define RMPU_ADDR_LSB 5
`define RMPU_BASE_SH_MSB 4
`define RMPU_BASE_SH_LSB 3
`define RMPU_BASE_AP_MSB 2
`define RMPU_BASE_AP_LSB 1
`define RMPU_BASE_XN 0
`define RMPU_LIMIT_IDX_MSB 3
`define RMPU_LIMIT_IDX_LSB 1
`define RMPU_LIMIT_EN 0

// ==========================================================
// Reset values and fixed encodings
`define RMPU_CTRL_RESET 3'h0
`define RMPU_SEL_RESET 8'h00
`define RMPU_REGION_COUNT 8'h08
`define RMPU_NO_REGIONS 8'h00
`define RMPU_LOW_ZERO 5'h00
`define RMPU_LIMIT_LOW 5'h1F
`define RMPU_ATTR_STRONG 8'h00
`define RMPU_SCS_TOP 20'hE000_E
`define RMPU_SYS_TOP 3'h7

// ==========================================================
// Timing: bus answer and check result, in clock cycles
`define RMPU_BUS_ACK_CYCLES 1
`define RMPU_CHECK_CYCLES 1

`endif

// ### rtl/rmpu_top.v
`timescale 1ns/1ps
`include "rmpu_defs.vh"

module rmpu_top #(
  parameter PRESENT = 1,
  parameter SECURE_EXT = 1,
  parameter REGIONS = 8,
  parameter IDXW = 3,
  parameter [7:0] DEFAULT_ATTR = 8'h44
) (
  input wire core_clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire bus_nonsecure,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire acc_valid,
  input wire [31:0] acc_addr,
  input wire acc_priv,
  input wire acc_write,
  input wire acc_fetch,
  input wire acc_vector,
  input wire acc_nonsecure,
  input wire acc_neg_priority,
  output reg chk_valid,
  output reg chk_fault,
  output reg chk_overlap,
  output reg chk_xn,
  output reg [7:0] chk_attr,
  output reg [1:0] chk_shareability
);

  localparam ENTRIES = 2 * REGIONS;

  // Storage is indexed by {bank, region}; the bank bit is tied to zero
  // when the security extension is left out, so only half is ever used.
  // Trade-off: the spare half costs area but keeps one decode path.

  // ==========================================================
  // Register storage, two banks of everything
  reg [2:0] ctrl [0:1];
  reg [7:0] rsel [0:1];
  reg [31:0] attr_low [0:1];
  reg [31:0] attr_high [0:1];
  reg [26:0] base_addr [0:ENTRIES-1];
  reg [4:0] base_flags [0:ENTRIES-1];
  reg [26:0] limit_addr [0:ENTRIES-1];
  reg [3:0] limit_flags [0:ENTRIES-1];

  wire [11:0] off = wb_adr_i[11:0];
  wire bus_bank = (SECURE_EXT != 0) & bus_nonsecure;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  reg is_base;
  reg is_limit;
  reg [11:0] alias_off;
  reg [7:0] sel_idx;
  reg sel_ok;
  reg [IDXW:0] sel_entry;
  reg [31:0] base_word;
  reg [31:0] limit_word;
  reg [31:0] next_rdata;

  // ==========================================================
  // Address decode and selector resolution
  always @* begin
    is_base = 1'b0;
    is_limit = 1'b0;
    alias_off = off - `RMPU_OFF_ALIAS_FIRST;
    sel_idx = rsel[bus_bank];
    if (off == `RMPU_OFF_BASE) begin
      is_base = 1'b1;
    end else if (off == `RMPU_OFF_LIMIT) begin
      is_limit = 1'b1;
    end else if (off >= `RMPU_OFF_ALIAS_FIRST && off <= `RMPU_OFF_ALIAS_LAST && off[1:0] == 2'b00) begin
      sel_idx = {rsel[bus_bank][7:2], alias_off[4:3] + 2'b01};
      is_base = ~alias_off[2];
      is_limit = alias_off[2];
    end
    sel_ok = (PRESENT != 0) && (sel_idx < REGIONS);
    sel_entry = {bus_bank, sel_idx[IDXW-1:0]};
  end

  // ==========================================================
  // Read mux
  always @* begin
    base_word = {base_addr[sel_entry], base_flags[sel_entry]};
    limit_word = {limit_addr[sel_entry], 1'b0, limit_flags[sel_entry]};
    next_rdata = 32'h0000_0000;
    case (off)
      `RMPU_OFF_TYPE: begin
        next_rdata = {16'h0000, (PRESENT != 0) ? `RMPU_REGION_COUNT : `RMPU_NO_REGIONS, 8'h00};
      end
      `RMPU_OFF_CTRL: begin
        next_rdata = {29'h0, ctrl[bus_bank]};
      end
      `RMPU_OFF_SEL: begin
        next_rdata = {24'h00_0000, rsel[bus_bank]};
      end
      `RMPU_OFF_ATTR_LOW: begin
        next_rdata = attr_low[bus_bank];
      end
      `RMPU_OFF_ATTR_HIGH: begin
        next_rdata = attr_high[bus_bank];
      end
      default: begin
        if (sel_ok && is_base) begin
          next_rdata = base_word;
        end else if (sel_ok && is_limit) begin
          next_rdata = limit_word;
        end
      end
    endcase
  end

  // ==========================================================
  // Wishbone answer, one cycle after the request, unmapped reads zero
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // ==========================================================
  // Banked control, selector and indirection registers
  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_bank
      wire hit = wr && (bus_bank == b);
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          ctrl[b] <= `RMPU_CTRL_RESET;
          rsel[b] <= `RMPU_SEL_RESET;
          attr_low[b] <= 32'h0000_0000;
          attr_high[b] <= 32'h0000_0000;
        end else if (hit) begin
          // Each state writes its own copy
          if (off == `RMPU_OFF_CTRL && wb_sel_i[0]) begin
            ctrl[b] <= wb_dat_i[2:0];
          end
          if (off == `RMPU_OFF_SEL && wb_sel_i[0]) begin
            rsel[b] <= wb_dat_i[7:0];
          end
          if (off == `RMPU_OFF_ATTR_LOW) begin
            attr_low[b] <= (attr_low[b] & ~bmask) | (wb_dat_i & bmask);
          end
          if (off == `RMPU_OFF_ATTR_HIGH) begin
            attr_high[b] <= (attr_high[b] & ~bmask) | (wb_dat_i & bmask);
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Region entries; regions come up disabled
  genvar e;
  generate
    for (e = 0; e < ENTRIES; e = e + 1) begin : g_entry
      wire [31:0] bw = (base_word & ~bmask) | (wb_dat_i & bmask);
      wire [31:0] lw = (limit_word & ~bmask) | (wb_dat_i & bmask);
      wire mine = wr && sel_ok && (sel_entry == e);
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          base_addr[e] <= 27'h0;
          base_flags[e] <= 5'h00;
          limit_addr[e] <= 27'h0;
          limit_flags[e] <= 4'h0;
        end else if (mine && is_base) begin
          base_addr[e] <= bw[31:5];
          base_flags[e] <= bw[4:0];
        end else if (mine && is_limit) begin
          limit_addr[e] <= lw[31:5];
          limit_flags[e] <= lw[3:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Access check
  wire cb = (SECURE_EXT != 0) & acc_nonsecure;
  wire [2:0] cctl = ctrl[cb];
  // Handler bypass unless handler bit set
  // Handler bit with checking off acts as off
  wire checking = (PRESENT != 0) & cctl[`RMPU_CTRL_ENABLE] &
                  ~(acc_neg_priority & ~cctl[`RMPU_CTRL_HANDLER]);
  wire in_scs = (acc_addr[31:12] == `RMPU_SCS_TOP);
  wire in_sys = (acc_addr[31:29] == `RMPU_SYS_TOP);

  wire [REGIONS-1:0] hits;
  genvar r;
  generate
    for (r = 0; r < REGIONS; r = r + 1) begin : g_match
      localparam [IDXW-1:0] RI = r;
      wire [IDXW:0] ent = {cb, RI};
      assign hits[r] = limit_flags[ent][`RMPU_LIMIT_EN] &&
                       (acc_addr >= {base_addr[ent], `RMPU_LOW_ZERO}) &&
                       (acc_addr <= {limit_addr[ent], `RMPU_LIMIT_LOW});
    end
  endgenerate

  reg [IDXW-1:0] hit_idx;
  reg refuse;
  reg next_xn;
  reg [7:0] next_attr;
  reg [1:0] next_sh;
  integer k;

  // ==========================================================
  // Winning region: highest-numbered hit
  // Which one wins never matters; its fields are read only when exactly one region hits
  always @* begin
    hit_idx = {IDXW{1'b0}};
    for (k = 0; k < REGIONS; k = k + 1) begin
      if (hits[k]) begin
        hit_idx = k[IDXW-1:0];
      end
    end
  end

  // ==========================================================
  // Permission terms of the winning region
  wire [IDXW:0] win_entry = {cb, hit_idx};
  wire [4:0] hf = base_flags[win_entry];
  wire [3:0] lf = limit_flags[win_entry];
  wire [2:0] aidx = lf[`RMPU_LIMIT_IDX_MSB:`RMPU_LIMIT_IDX_LSB];
  wire [63:0] attrs = {attr_high[cb], attr_low[cb]};
  wire deny_level = ~acc_priv & ~hf[`RMPU_BASE_AP_LSB];
  wire deny_write = acc_write & hf[`RMPU_BASE_AP_MSB];
  wire deny_exec = acc_fetch & hf[`RMPU_BASE_XN];
  // Two or more hits
  // Overlap is judged before permissions, so a lenient region never masks it
  wire multi = |(hits & (hits - 1'b1));

  // ==========================================================
  // Access decision
  always @* begin
    refuse = 1'b0;
    next_xn = in_sys;
    next_attr = DEFAULT_ATTR;
    next_sh = 2'b00;
    if (in_scs) begin
      next_attr = `RMPU_ATTR_STRONG;
      next_xn = 1'b1;
      refuse = acc_fetch;
    end else if (!checking) begin
      refuse = acc_fetch & in_sys;
    end else if (acc_vector) begin
      refuse = 1'b0;
    end else if (multi) begin
      refuse = 1'b1;
    end else if (|hits) begin
      next_attr = attrs[aidx*8 +: 8];
      next_sh = hf[`RMPU_BASE_SH_MSB:`RMPU_BASE_SH_LSB];
      next_xn = hf[`RMPU_BASE_XN];
      // Fetch needs read and no execute-never
      refuse = deny_level | deny_write | deny_exec;
    end else begin
      refuse = ~(acc_priv & cctl[`RMPU_CTRL_BACKGROUND]) | (acc_fetch & in_sys);
    end
  end

  // ==========================================================
  // Registered check result, one cycle after the access
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_valid <= 1'b0;
      chk_fault <= 1'b0;
      chk_overlap <= 1'b0;
      chk_xn <= 1'b0;
      chk_attr <= 8'h00;
      chk_shareability <= 2'b00;
    end else begin
      chk_valid <= acc_valid;
      chk_fault <= acc_valid & refuse;
      chk_overlap <= acc_valid & checking & multi & ~in_scs & ~acc_vector;
      chk_xn <= next_xn;
      chk_attr <= next_attr;
      chk_shareability <= next_sh;
    end
  end

endmodule // rmpu_top

// ### verification/rmpu_core_model.sv
`timescale 1ns/1ps
// ====================
// Core fetch and load/store side
module rmpu_core_model (
  input wire core_clk,
  input wire rst_b,
  input wire req_valid,
  input wire [31:0] req_addr,
  input wire [4:0] req_kind,
  output reg acc_valid,
  output reg [31:0] acc_addr,
  output reg [4:0] acc_kind
);
  // Idle cycles churn address and kind, so stale values never pass for a request
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_valid <= 1'b0;
      acc_addr <= 32'h0;
      acc_kind <= 5'h0;
    end else begin
      acc_valid <= req_valid;
      acc_addr <= req_valid ? req_addr : ~acc_addr;
      acc_kind <= req_valid ? req_kind : ~acc_kind;
    end
  end
endmodule // rmpu_core_model

// ### verification/rmpu_top_sva.sv
`timescale 1ns/1ps
`include "rmpu_defs.vh"
// ====================
// Port checker
module rmpu_top_sva (
  input wire core_clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire acc_valid,
  input wire [31:0] acc_addr,
  input wire acc_fetch,
  input wire acc_vector,
  input wire chk_valid,
  input wire chk_fault,
  input wire chk_overlap,
  input wire chk_xn,
  input wire [7:0] chk_attr
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  wire rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  wire scs = acc_valid & (acc_addr[31:12] == `RMPU_SCS_TOP);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_type_fixed: assert property (
    rd && wb_adr_i[11:0] == `RMPU_OFF_TYPE |=> wb_dat_o == {16'h0, `RMPU_REGION_COUNT, 8'h0}) else $error("type");
  a_gap_zero: assert property (rd && wb_adr_i[11:0] == 12'hDBC |=> wb_dat_o == 32'h0) else $error("gap");
  a_check_latency: assert property (1'b1 |=> chk_valid == $past(acc_valid)) else $error("latency");
  a_fault_valid: assert property (chk_fault |-> chk_valid) else $error("stray fault");
  a_overlap_fault: assert property (chk_overlap |-> chk_fault) else $error("overlap");
  a_scs_attr: assert property (scs |=> chk_xn && chk_attr == `RMPU_ATTR_STRONG) else $error("scs attr");
  a_scs_fetch: assert property (scs && acc_fetch |=> chk_fault) else $error("scs fetch");
  a_scs_data: assert property (scs && !acc_fetch |=> !chk_fault) else $error("scs data");
  a_vector_open: assert property (acc_valid && acc_vector && !acc_fetch |=> !chk_fault) else $error("vec");
endmodule // rmpu_top_sva

bind rmpu_top rmpu_top_sva i_sva (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_valid(acc_valid),
  .acc_addr(acc_addr), .acc_fetch(acc_fetch), .acc_vector(acc_vector), .chk_valid(chk_valid),
  .chk_fault(chk_fault), .chk_overlap(chk_overlap), .chk_xn(chk_xn), .chk_attr(chk_attr));

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg core_clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, bank = 1'b0, rv = 1'b0;
  reg [31:0] adr = 32'h0, wdat = 32'h0, ra = 32'h0, r;
  reg [4:0] rk = 5'h0;
  reg [31:0] bv [0:7];
  wire [31:0] rdat, aa;
  wire [4:0] ak;
  wire [7:0] c_a;
  wire [1:0] c_s;
  wire ack, av, c_v, c_f, c_o, c_x;
  integer seed = 32'hb7f3_af9a;
  integer fails = 0, total_checks = 0, i;
  always #50 core_clk = ~core_clk;
  rmpu_core_model i_core (.core_clk(core_clk), .rst_b(rst_b), .req_valid(rv), .req_addr(ra), .req_kind(rk),
    .acc_valid(av), .acc_addr(aa), .acc_kind(ak));
  rmpu_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .bus_nonsecure(bank), .wb_dat_o(rdat), .wb_ack_o(ack),
    .acc_valid(av), .acc_addr(aa), .acc_priv(ak[0]), .acc_write(ak[1]), .acc_fetch(ak[2]), .acc_vector(ak[3]),
    .acc_nonsecure(bank), .acc_neg_priority(ak[4]), .chk_valid(c_v), .chk_fault(c_f), .chk_overlap(c_o),
    .chk_xn(c_x), .chk_attr(c_a), .chk_shareability(c_s));
  // ====================
  // Checks and bus helpers
  task test_done;
    begin
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %0t reg %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wb(input w, input [11:0] a, input [31:0] dv);
    integer n;
    begin
      @(posedge core_clk);
      {cyc, stb, we} <= {2'b11, w};
      adr <= {20'hE000_E, a};
      wdat <= dv;
      n = 0;
      @(posedge core_clk);
      while (ack !== 1'b1 && n < 20) begin
        @(posedge core_clk);
        n = n + 1;
      end
      r = rdat;
      {cyc, stb} <= 2'b00;
      if (n == 20) begin
        fails = fails + 1;
        $display("ERROR %0t bus timeout", $time);
        test_done;
      end
    end
  endtask
  // Kind bits: neg priority, vector, fetch, write, privileged
  task acc(input [31:0] a, input [4:0] k, input [1:0] f);
    begin
      @(posedge core_clk);
      {rv, ra, rk} <= {1'b1, a, k};
      @(posedge core_clk);
      rv <= 1'b0;
      @(posedge core_clk);
      #1;
      total_checks = total_checks + 1;
      if ({c_v, c_f, c_o} !== {1'b1, f}) begin
        fails = fails + 1;
        $display("ERROR %0t access %h got %b", $time, a, {c_v, c_f, c_o});
      end
    end
  endtask
  // Bits: fetch, write, privileged, read-only, any level, execute-never
  function flt(input [5:0] k);
    flt = !(k[3] | k[1]) | (k[4] & k[2]) | (k[5] & k[0]);
  endfunction
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    wb(1'b0, 12'hD90, 32'h0);
    chk(r, 32'h0000_0800);
    wb(1'b0, 12'hD94, 32'h0);
    chk(r, 32'h0);
    wb(1'b1, 12'hDBC, 32'hFFFF_FFFF);
    wb(1'b0, 12'hDBC, 32'h0);
    chk(r, 32'h0);
    wb(1'b1, 12'hD94, 32'hFFFF_FFFF);
    wb(1'b0, 12'hD94, 32'h0);
    chk(r, 32'h7);
    bank <= 1'b1;
    wb(1'b0, 12'hD94, 32'h0);
    chk(r, 32'h0);
    bank <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      bv[i] = $random(seed);
      wb(1'b1, 12'hD98, i);
      wb(1'b1, 12'hD9C, bv[i]);
      wb(1'b1, 12'hDA0, bv[i] & 32'hFFFF_FFFE);
    end
    for (i = 0; i < 8; i = i + 1) begin
      wb(1'b1, 12'hD98, i);
      wb(1'b0, 12'hD9C, 32'h0);
      chk(r, bv[i]);
      wb(1'b0, 12'hDA0, 32'h0);
      chk(r, bv[i] & 32'hFFFF_FFEE);
    end
    wb(1'b1, 12'hD98, 32'h4);
    wb(1'b1, 12'hDB4, 32'h1234_5660);
    wb(1'b1, 12'hD98, 32'h7);
    wb(1'b0, 12'hD9C, 32'h0);
    chk(r, 32'h1234_5660);
    $display("register tests done");
    wb(1'b1, 12'hD98, 32'h0);
    wb(1'b1, 12'hD9C, 32'h2000_0012);
    wb(1'b1, 12'hDA0, 32'h2000_0FE3);
    wb(1'b1, 12'hDC0, 32'h0000_A500);
    wb(1'b1, 12'hD94, 32'h1);
    acc(32'h2000_0FFF, 5'h00, 2'b00);
    chk({22'h0, c_s, c_a}, 32'h2A5);
    acc(32'h2000_1000, 5'h00, 2'b10);
    acc(32'h1FFF_FFFF, 5'h01, 2'b10);
    acc(32'h3000_0000, 5'h10, 2'b00);
    acc(32'h0000_0000, 5'h08, 2'b00);
    acc(32'hE000_ED00, 5'h00, 2'b00);
    acc(32'hE000_ED00, 5'h04, 2'b10);
    wb(1'b1, 12'hD94, 32'h3);
    acc(32'h3000_0000, 5'h10, 2'b10);
    wb(1'b1, 12'hD94, 32'h4);
    acc(32'h3000_0000, 5'h00, 2'b00);
    wb(1'b1, 12'hD94, 32'h5);
    acc(32'h3000_0000, 5'h01, 2'b00);
    acc(32'h3000_0000, 5'h00, 2'b10);
    for (i = 0; i < 64; i = i + 1) begin
      if (i[5:4] != 2'b11) begin
        wb(1'b1, 12'hD9C, 32'h2000_0010 | i[2:0]);
        acc(32'h2000_0000 | ($random(seed) & 32'hFFF), {2'b00, i[5:3]}, {flt(i[5:0]), 1'b0});
      end
    end
    wb(1'b1, 12'hD98, 32'h1);
    wb(1'b1, 12'hD9C, 32'h2000_0802);
    wb(1'b1, 12'hDA0, 32'h2000_0FE1);
    acc(32'h2000_0900, 5'h01, 2'b11);
    wb(1'b1, 12'hD98, 32'h0);
    wb(1'b1, 12'hDA0, 32'h2000_0FE2);
    wb(1'b1, 12'hD94, 32'h1);
    acc(32'h2000_0100, 5'h00, 2'b10);
    acc(32'h2000_0900, 5'h00, 2'b00);
    $display("checking tests done");
    test_done;
  end
endmodule // testbench
